// ===== logic/tcwu_pkg.sv
`default_nettype none
package tcwu_pkg;
   // -------------------------------------------------------------
   // Register offsets
   // -------------------------------------------------------------
   localparam logic [7:0] TCWU_CTRL_OFS = 8'h00;
   localparam logic [7:0] TCWU_COUNT_OFS = 8'h04;
   localparam logic [7:0] TCWU_CMP_OFS = 8'h08;
   localparam logic [7:0] TCWU_FLAG_OFS = 8'h0c;
   localparam logic [7:0] TCWU_PIN_OFS = 8'h10;
   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int TCWU_WM_LSB = 0;
   localparam int TCWU_CS_LSB = 2;
   localparam int TCWU_COM_LSB = 5;
   localparam int TCWU_FORCE_BIT = 7;
   localparam int TCWU_OVF_BIT = 0;
   localparam int TCWU_CMPF_BIT = 1;
   localparam int TCWU_DIR_BIT = 0;
   localparam int TCWU_PORT_BIT = 1;
   localparam int TCWU_OC_BIT = 2;
   // -------------------------------------------------------------
   // Values and reset values
   // -------------------------------------------------------------
   localparam logic [7:0] TCWU_MAX = 8'hff;
   localparam logic [7:0] TCWU_BOTTOM = 8'h00;
   localparam logic [7:0] TCWU_PRE_MAX = 8'hfe;
   localparam logic [7:0] TCWU_RST8 = 8'h00;
   localparam logic [1:0] TCWU_WM_NORMAL = 2'h0;
   localparam logic [1:0] TCWU_WM_PHASE = 2'h1;
   localparam logic [1:0] TCWU_WM_CLEAR = 2'h2;
   localparam logic [1:0] TCWU_WM_FAST = 2'h3;
   localparam logic [1:0] TCWU_COM_OFF = 2'h0;
   localparam logic [1:0] TCWU_COM_TOGGLE = 2'h1;
   localparam logic [1:0] TCWU_COM_CLEAR = 2'h2;
   localparam logic [1:0] TCWU_COM_SET = 2'h3;
   // -------------------------------------------------------------
   // Prescaler masks for divide by 1, 8, 32, 64, 128, 256, 1024
   // -------------------------------------------------------------
   localparam int TCWU_PRE_W = 10;
   localparam logic [9:0] TCWU_MASK_1 = 10'h000;
   localparam logic [9:0] TCWU_MASK_8 = 10'h007;
   localparam logic [9:0] TCWU_MASK_32 = 10'h01f;
   localparam logic [9:0] TCWU_MASK_64 = 10'h03f;
   localparam logic [9:0] TCWU_MASK_128 = 10'h07f;
   localparam logic [9:0] TCWU_MASK_256 = 10'h0ff;
   localparam logic [9:0] TCWU_MASK_1024 = 10'h3ff;
   typedef enum logic [2:0] {
      TCWU_CS_STOP, TCWU_CS_1, TCWU_CS_8, TCWU_CS_32,
      TCWU_CS_64, TCWU_CS_128, TCWU_CS_256, TCWU_CS_1024
   } tcwu_cs_t;
endpackage
`default_nettype wire

// ===== logic/tcwu_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tcwu_tick_if;
   import tcwu_pkg::*;
   tcwu_cs_t clock_select;
   logic tick;
   modport core (output clock_select, input tick);
   modport pre (input clock_select, output tick);
endinterface
`default_nettype wire

// ===== logic/tcwu_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module tcwu_prescaler
   import tcwu_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   tcwu_tick_if.pre tk
);
   logic [TCWU_PRE_W-1:0] pre_reg;
   logic [TCWU_PRE_W-1:0] mask;
   logic tick_reg;

   // -------------------------------------------------------------
   // Free-running divider
   // -------------------------------------------------------------
   // The divider runs free, so a new setting takes effect within one
   // period of the slowest rate instead of restarting the phase.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_reg <= '0;
      end else begin
         pre_reg <= pre_reg + 10'h001;
      end
   end

   always_comb begin
      case (tk.clock_select)
         TCWU_CS_1: mask = TCWU_MASK_1;
         TCWU_CS_8: mask = TCWU_MASK_8;
         TCWU_CS_32: mask = TCWU_MASK_32;
         TCWU_CS_64: mask = TCWU_MASK_64;
         TCWU_CS_128: mask = TCWU_MASK_128;
         TCWU_CS_256: mask = TCWU_MASK_256;
         TCWU_CS_1024: mask = TCWU_MASK_1024;
         default: mask = TCWU_MASK_1;
      endcase
   end

   // -------------------------------------------------------------
   // Timer clock enable
   // -------------------------------------------------------------
   always_comb begin
      tick_reg = (tk.clock_select != TCWU_CS_STOP) &&
                 ((pre_reg & mask) == mask);
   end

   assign tk.tick = tick_reg;
endmodule // tcwu_prescaler
`default_nettype wire

// ===== logic/tcwu_timer.sv
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module tcwu_timer
   import tcwu_pkg::*;
(
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic OVF_ACK,
   input wire logic CMP_ACK,
   output logic OVERFLOW_FLAG,
   output logic COMPARE_FLAG,
   output logic COMPARE_PIN_O,
   output logic COMPARE_PIN_OE
);
   tcwu_tick_if tk ();

   logic pready_reg, pslverr_reg, hit_next;
   logic [31:0] prdata_reg, rdata_next;
   logic wr_done, wr_ctrl, wr_count, wr_cmp, wr_flag, wr_pin;

   logic [1:0] waveform_mode_reg, compare_output_mode_reg;
   tcwu_cs_t cs_reg;
   logic [7:0] counter_value_reg, counter_value_next;
   logic [7:0] compare_value_reg, compare_buf_reg;
   logic compare_output_reg, compare_output_next;
   logic overflow_flag_reg, compare_flag_reg, match_seen_reg, block_reg;
   logic compare_pin_direction_reg, port_value_reg;
   logic pin_o_reg, pin_oe_reg;

   logic tick, pwm_mode, match, wrap, force_now, ovf_set;
   logic [1:0] com_w;

   tcwu_prescaler u_pre (
      .clk(MCLK),
      .rst_n(RESETN),
      .tk(tk.pre)
   );

   assign tk.clock_select = cs_reg;
   assign tick = tk.tick;

   // -------------------------------------------------------------
   // APB slave
   // -------------------------------------------------------------
   // One wait state: the answer is built in the first access cycle
   // so that every bus output leaves a flip-flop.
   assign wr_done = PSEL && PENABLE && pready_reg && PWRITE;
   assign wr_ctrl = wr_done && (PADDR == TCWU_CTRL_OFS);
   assign wr_count = wr_done && (PADDR == TCWU_COUNT_OFS);
   assign wr_cmp = wr_done && (PADDR == TCWU_CMP_OFS);
   assign wr_flag = wr_done && (PADDR == TCWU_FLAG_OFS);
   assign wr_pin = wr_done && (PADDR == TCWU_PIN_OFS);

   always_comb begin
      rdata_next = 32'h0000_0000;
      hit_next = 1'b1;
      case (PADDR)
         TCWU_CTRL_OFS: begin
            rdata_next[TCWU_WM_LSB+:2] = waveform_mode_reg;
            rdata_next[TCWU_CS_LSB+:3] = cs_reg;
            rdata_next[TCWU_COM_LSB+:2] = compare_output_mode_reg;
         end
         TCWU_COUNT_OFS: rdata_next[7:0] = counter_value_reg;
         TCWU_CMP_OFS: rdata_next[7:0] = pwm_mode ? compare_buf_reg :
                                         compare_value_reg;
         TCWU_FLAG_OFS: begin
            rdata_next[TCWU_OVF_BIT] = overflow_flag_reg;
            rdata_next[TCWU_CMPF_BIT] = compare_flag_reg;
         end
         TCWU_PIN_OFS: begin
            rdata_next[TCWU_DIR_BIT] = compare_pin_direction_reg;
            rdata_next[TCWU_PORT_BIT] = port_value_reg;
            rdata_next[TCWU_OC_BIT] = compare_output_reg;
         end
         default: hit_next = 1'b0;
      endcase
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= PSEL && PENABLE && !pready_reg;
         pslverr_reg <= PSEL && PENABLE && !pready_reg && !hit_next;
         if (PSEL && PENABLE && !pready_reg && !PWRITE) begin
            prdata_reg <= rdata_next;
         end
      end
   end

   // -------------------------------------------------------------
   // Control register
   // -------------------------------------------------------------
   // The compare output mode is not staged: it is read directly by
   // the waveform logic at the next match.
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         waveform_mode_reg <= TCWU_WM_NORMAL;
         compare_output_mode_reg <= TCWU_COM_OFF;
         cs_reg <= TCWU_CS_STOP;
      end else if (wr_ctrl) begin
         waveform_mode_reg <= PWDATA[TCWU_WM_LSB+:2];
         compare_output_mode_reg <= PWDATA[TCWU_COM_LSB+:2];
         cs_reg <= tcwu_cs_t'(PWDATA[TCWU_CS_LSB+:3]);
      end
   end

   assign com_w = PWDATA[TCWU_COM_LSB+:2];
   assign force_now = wr_ctrl && PWDATA[TCWU_FORCE_BIT] &&
                      (PWDATA[TCWU_WM_LSB+:2] != TCWU_WM_FAST) &&
                      (PWDATA[TCWU_WM_LSB+:2] != TCWU_WM_PHASE);

   // -------------------------------------------------------------
   // Compare value and its buffer
   // -------------------------------------------------------------
   assign pwm_mode = (waveform_mode_reg == TCWU_WM_FAST) ||
                     (waveform_mode_reg == TCWU_WM_PHASE);
   assign wrap = tick && (counter_value_reg == TCWU_MAX);

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         compare_buf_reg <= TCWU_RST8;
      end else if (wr_cmp) begin
         compare_buf_reg <= PWDATA[7:0];
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         compare_value_reg <= TCWU_RST8;
      end else if (wr_cmp && !pwm_mode) begin
         compare_value_reg <= PWDATA[7:0];
      end else if (pwm_mode && wrap) begin
         compare_value_reg <= compare_buf_reg;
      end
   end

   // -------------------------------------------------------------
   // Counter
   // -------------------------------------------------------------
   // A software write to the counter masks the comparator for the
   // next timer cycle, so equal values can be loaded without a match.
   assign match = (counter_value_reg == compare_value_reg) && !block_reg;

   always_comb begin
      case (waveform_mode_reg)
         TCWU_WM_NORMAL, TCWU_WM_FAST: begin
            counter_value_next = counter_value_reg + 8'h01;
         end
         TCWU_WM_CLEAR: begin
            counter_value_next = match ? TCWU_BOTTOM :
                                 counter_value_reg + 8'h01;
         end
         default: counter_value_next = counter_value_reg;
      endcase
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         counter_value_reg <= TCWU_RST8;
      end else if (wr_count) begin
         counter_value_reg <= PWDATA[7:0];
      end else if (tick) begin
         counter_value_reg <= counter_value_next;
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         block_reg <= 1'b0;
      end else if (wr_count) begin
         block_reg <= 1'b1;
      end else if (tick) begin
         block_reg <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // Flags
   // -------------------------------------------------------------
   always_comb begin
      case (waveform_mode_reg)
         TCWU_WM_NORMAL: ovf_set = wrap;
         TCWU_WM_CLEAR: ovf_set = wrap;
         TCWU_WM_FAST: begin
            ovf_set = tick && (counter_value_reg == TCWU_PRE_MAX);
         end
         default: ovf_set = 1'b0;
      endcase
   end

   // Setting wins over a clear in the same cycle.
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         overflow_flag_reg <= 1'b0;
      end else if (ovf_set) begin
         overflow_flag_reg <= 1'b1;
      end else if (OVF_ACK ||
                   (wr_flag && PWDATA[TCWU_OVF_BIT])) begin
         overflow_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         match_seen_reg <= 1'b0;
      end else if (tick) begin
         match_seen_reg <= match && !pwm_mode ? 1'b1 :
                           match && (waveform_mode_reg == TCWU_WM_FAST);
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         compare_flag_reg <= 1'b0;
      end else if (tick && match_seen_reg) begin
         compare_flag_reg <= 1'b1;
      end else if (CMP_ACK ||
                   (wr_flag && PWDATA[TCWU_CMPF_BIT])) begin
         compare_flag_reg <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // Waveform generator
   // -------------------------------------------------------------
   // In fast PWM clear and set modes a compare value at maximum skips the match action,
   // leaving the wrap action alone so the level stays constant.
   always_comb begin
      compare_output_next = compare_output_reg;
      if (force_now) begin
         case (com_w)
            TCWU_COM_TOGGLE: compare_output_next = !compare_output_reg;
            TCWU_COM_CLEAR: compare_output_next = 1'b0;
            TCWU_COM_SET: compare_output_next = 1'b1;
            default: compare_output_next = compare_output_reg;
         endcase
      end else if (tick) begin
         case (waveform_mode_reg)
            TCWU_WM_NORMAL, TCWU_WM_CLEAR: begin
               if (match) begin
                  case (compare_output_mode_reg)
                     TCWU_COM_TOGGLE: begin
                        compare_output_next = !compare_output_reg;
                     end
                     TCWU_COM_CLEAR: compare_output_next = 1'b0;
                     TCWU_COM_SET: compare_output_next = 1'b1;
                     default: compare_output_next = compare_output_reg;
                  endcase
               end
            end
            TCWU_WM_FAST: begin
               case (compare_output_mode_reg)
                  TCWU_COM_TOGGLE: begin
                     if (match) begin
                        compare_output_next = !compare_output_reg;
                     end
                  end
                  TCWU_COM_CLEAR: begin
                     if (counter_value_reg == TCWU_MAX) begin
                        compare_output_next = 1'b1;
                     end else if (match) begin
                        compare_output_next = 1'b0;
                     end
                  end
                  TCWU_COM_SET: begin
                     if (counter_value_reg == TCWU_MAX) begin
                        compare_output_next = 1'b0;
                     end else if (match) begin
                        compare_output_next = 1'b1;
                     end
                  end
                  default: compare_output_next = compare_output_reg;
               endcase
            end
            default: compare_output_next = compare_output_reg;
         endcase
      end
   end

   // Forcing touches only this state: the counter and flags ignore it.
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         compare_output_reg <= 1'b0;
      end else begin
         compare_output_reg <= compare_output_next;
      end
   end

   // -------------------------------------------------------------
   // Pin control
   // -------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         compare_pin_direction_reg <= 1'b0;
         port_value_reg <= 1'b0;
      end else if (wr_pin) begin
         compare_pin_direction_reg <= PWDATA[TCWU_DIR_BIT];
         port_value_reg <= PWDATA[TCWU_PORT_BIT];
      end
   end

   // The override ignores the waveform mode, and the state can be
   // prepared by forcing while the mode is zero and the pin is idle.
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         pin_o_reg <= 1'b0;
         pin_oe_reg <= 1'b0;
      end else begin
         pin_o_reg <= (compare_output_mode_reg != TCWU_COM_OFF) ?
                      compare_output_reg : port_value_reg;
         pin_oe_reg <= compare_pin_direction_reg;
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   assign PRDATA = prdata_reg;
   assign PREADY = pready_reg;
   assign PSLVERR = pslverr_reg;
   assign OVERFLOW_FLAG = overflow_flag_reg;
   assign COMPARE_FLAG = compare_flag_reg;
   assign COMPARE_PIN_O = pin_o_reg;
   assign COMPARE_PIN_OE = pin_oe_reg;
endmodule // tcwu_timer
`default_nettype wire

// ===== dv/tcwu_timer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tcwu_timer_monitor
   import tcwu_pkg::*;
(
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic OVF_ACK,
   input wire logic CMP_ACK,
   input wire logic OVERFLOW_FLAG,
   input wire logic COMPARE_FLAG,
   input wire logic COMPARE_PIN_O,
   input wire logic COMPARE_PIN_OE
);
   logic [1:0] com_reg;
   logic port_reg;
   logic wr_ok;
   logic fw_ovf;
   logic fw_cmp;
   assign wr_ok = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
   assign fw_ovf = wr_ok && PADDR == TCWU_FLAG_OFS && PWDATA[0];
   assign fw_cmp = wr_ok && PADDR == TCWU_FLAG_OFS && PWDATA[1];
   // Mirrors of the mode and port bits, so the pin source is known.
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         com_reg <= 2'h0;
         port_reg <= 1'b0;
      end else if (wr_ok) begin
         if (PADDR == TCWU_CTRL_OFS) com_reg <= PWDATA[6:5];
         if (PADDR == TCWU_PIN_OFS) port_reg <= PWDATA[1];
      end
   end
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESETN);
   chk_ready_wait: assert property (
      PSEL && PENABLE && !$past(PENABLE) |-> !PREADY ##1 PREADY)
      else $error("ready not after one wait state");
   chk_err_decode: assert property (
      PREADY |-> PSLVERR == (PADDR > TCWU_PIN_OFS || PADDR[1:0] != 2'h0))
      else $error("error response wrong for address");
   chk_read_upper: assert property (
      PREADY && !PWRITE |-> PRDATA[31:8] == 24'h0)
      else $error("upper read bits not zero");
   chk_dir_pin: assert property (
      wr_ok && PADDR == TCWU_PIN_OFS
      |-> ##2 COMPARE_PIN_OE == $past(PWDATA[0], 2))
      else $error("pin enable does not follow direction");
   chk_port_pass: assert property (
      $past(com_reg) == 2'h0 |-> COMPARE_PIN_O == $past(port_reg))
      else $error("pin not port value with override off");
   chk_force_pin: assert property (
      wr_ok && PADDR == TCWU_CTRL_OFS && PWDATA[7] && PWDATA[6] && !PWDATA[0]
      |-> ##2 COMPARE_PIN_O == $past(PWDATA[5], 2))
      else $error("forced compare not on pin");
   chk_ovf_cause: assert property (
      $fell(OVERFLOW_FLAG) |-> $past(OVF_ACK) || $past(OVF_ACK, 2)
      || $past(fw_ovf) || $past(fw_ovf, 2))
      else $error("overflow flag cleared without cause");
   chk_cmpf_cause: assert property (
      $fell(COMPARE_FLAG) |-> $past(CMP_ACK) || $past(CMP_ACK, 2)
      || $past(fw_cmp) || $past(fw_cmp, 2))
      else $error("compare flag cleared without cause");
   cover property (PREADY && PSLVERR);
   cover property ($rose(COMPARE_FLAG));
   cover property (OVF_ACK && OVERFLOW_FLAG);
endmodule // tcwu_timer_monitor
bind tcwu_timer tcwu_timer_monitor u_tcwu_timer_monitor (.MCLK, .RESETN,
   .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
   .OVF_ACK, .CMP_ACK, .OVERFLOW_FLAG, .COMPARE_FLAG, .COMPARE_PIN_O,
   .COMPARE_PIN_OE);
`default_nettype wire

// ===== dv/tcwu_pin_load.sv
`timescale 1ns/1ps
`default_nettype none
module tcwu_pin_load (
   input wire logic clk,
   input wire logic pin_o,
   input wire logic pin_oe,
   output logic level,
   output int high_cnt,
   output int edge_cnt
);
   logic last_level = 1'b0;
   int hc = 0;
   int ec = 0;
   // A weak pull-down holds the node low while the pin is not driven.
   assign level = pin_oe ? pin_o : 1'b0;
   assign high_cnt = hc;
   assign edge_cnt = ec;
   always @(posedge clk) begin
      last_level <= level;
      if (level) hc <= hc + 1;
      if (level != last_level) ec <= ec + 1;
   end
endmodule // tcwu_pin_load
`default_nettype wire

// ===== dv/test_timer_compare_waveform_unit.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
   $display("MISMATCH %0t got %0h exp %0h", $time, a, b); end end
module test_timer_compare_waveform_unit;
   import tcwu_pkg::*;
   logic MCLK = 1'b0;
   logic RESETN = 1'b0;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0;
   logic OVF_ACK = 1'b0;
   logic CMP_ACK = 1'b0;
   logic [31:0] PRDATA;
   logic PREADY, PSLVERR, OVERFLOW_FLAG, COMPARE_FLAG, COMPARE_PIN_O;
   logic COMPARE_PIN_OE, level;
   int high_cnt, edge_cnt, h, e;
   int failures = 0;
   int checks = 0;
   logic [32:0] exp_q[$];
   logic [31:0] seed = 32'd12940;
   logic [31:0] tab [5] = '{32'h00402041, 32'h004030bf, 32'h00002001,
      32'h00ff2100, 32'h00ff3000};
   always #2.5 MCLK = ~MCLK;
   tcwu_timer u_tcwu_timer (.MCLK, .RESETN, .PSEL, .PENABLE, .PWRITE,
      .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .OVF_ACK, .CMP_ACK,
      .OVERFLOW_FLAG, .COMPARE_FLAG, .COMPARE_PIN_O, .COMPARE_PIN_OE);
   tcwu_pin_load u_tcwu_pin_load (.clk(MCLK), .pin_o(COMPARE_PIN_O),
      .pin_oe(COMPARE_PIN_OE), .level, .high_cnt, .edge_cnt);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic end_of_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge MCLK);
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [32:0] x);
      int n;
      @(posedge MCLK);
      if (!w) exp_q.push_back(x);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      n = 0;
      do begin
         @(posedge MCLK);
         n++;
      end while (PREADY !== 1'b1 && n < 20);
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (PREADY !== 1'b1) begin
         failures++;
         $display("MISMATCH %0t no ready", $time);
         end_of_test();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] x);
      apb(1'b0, a, 32'h0, x);
   endtask
   task automatic ack(input logic ovf);
      @(posedge MCLK);
      if (ovf) OVF_ACK <= 1'b1;
      else CMP_ACK <= 1'b1;
      @(posedge MCLK);
      OVF_ACK <= 1'b0;
      CMP_ACK <= 1'b0;
   endtask
   task automatic meas(input int n);
      int h0, e0;
      h0 = high_cnt;
      e0 = edge_cnt;
      wt(n);
      h = high_cnt - h0;
      e = edge_cnt - e0;
   endtask
   always @(posedge MCLK) begin
      if (PSEL && PENABLE && !PWRITE && PREADY === 1'b1) begin
         if (exp_q.size() == 0) begin
            failures++;
            $display("MISMATCH %0t unexpected read", $time);
         end else `CHK({PSLVERR, PRDATA}, exp_q.pop_front())
      end
   end
   initial begin
      #250000;
      failures++;
      $display("MISMATCH %0t timeout", $time);
      end_of_test();
   end
   initial begin
      logic [7:0] c;
      repeat (2) @(posedge MCLK);
      RESETN <= 1'b1;
      for (int i = 0; i < 6; i++) rd(8'(4 * i), {i == 5, 32'h0});
      $display("test reset done");
      wr(TCWU_CTRL_OFS, 32'he0);
      rd(TCWU_PIN_OFS, 33'h4);
      `CHK(level, 1'b0)
      wr(TCWU_PIN_OFS, 32'h1);
      wt(2);
      `CHK(level, 1'b1)
      wr(TCWU_CTRL_OFS, 32'hc0);
      rd(TCWU_PIN_OFS, 33'h1);
      wr(TCWU_CTRL_OFS, 32'ha0);
      rd(TCWU_PIN_OFS, 33'h5);
      rd(TCWU_FLAG_OFS, 33'h0);
      rd(TCWU_COUNT_OFS, 33'h0);
      $display("test force done");
      wr(TCWU_COUNT_OFS, 32'hf0);
      wr(TCWU_CTRL_OFS, 32'h04);
      wt(40);
      wr(TCWU_CTRL_OFS, 32'h0);
      rd(TCWU_FLAG_OFS, 33'h3);
      `CHK({COMPARE_FLAG, OVERFLOW_FLAG}, 2'h3)
      wr(TCWU_FLAG_OFS, 32'h3);
      rd(TCWU_FLAG_OFS, 33'h0);
      $display("test normal done");
      wr(TCWU_CTRL_OFS, 32'h26);
      for (int i = 0; i < 4; i++) begin
         c = (i == 0) ? 8'h00 : 8'(rnd()) & 8'h0f;
         wr(TCWU_CMP_OFS, {24'h0, c});
         wt(300);
         meas(8 * (int'(c) + 1));
         `CHK(e, 8)
      end
      wr(TCWU_CTRL_OFS, 32'he6);
      wr(TCWU_CTRL_OFS, 32'h06);
      wt(4);
      meas(64);
      `CHK(e, 0)
      rd(TCWU_PIN_OFS, 33'h5);
      wr(TCWU_PIN_OFS, 32'h3);
      wt(2);
      `CHK(level, 1'b1)
      $display("test clear on match done");
      wr(TCWU_PIN_OFS, 32'h1);
      foreach (tab[i]) begin
         wr(TCWU_CMP_OFS, {24'h0, tab[i][23:16]});
         wr(TCWU_CTRL_OFS, {25'h0, tab[i][13:12], 5'h07});
         wt(600);
         meas(256);
         `CHK(h, int'(tab[i][8:0]))
      end
      wr(TCWU_CMP_OFS, 32'h10);
      wr(TCWU_CTRL_OFS, 32'h27);
      wt(600);
      meas(512);
      `CHK(e, 2)
      `CHK(h, 256)
      wr(TCWU_CTRL_OFS, 32'h0);
      rd(TCWU_FLAG_OFS, 33'h3);
      ack(1'b0);
      rd(TCWU_FLAG_OFS, 33'h1);
      `CHK({COMPARE_FLAG, OVERFLOW_FLAG}, 2'h1)
      ack(1'b1);
      rd(TCWU_FLAG_OFS, 33'h0);
      `CHK({COMPARE_FLAG, OVERFLOW_FLAG}, 2'h0)
      $display("test fast pwm done");
      end_of_test();
   end
endmodule // test_timer_compare_waveform_unit
`default_nettype wire
